// *** verilog/asw_top.sv ***
// What this block does
// - enable rise captures scaled input as reference
// - scaled value is input times gain plus offset
// - gain signed, magnitude up to 10.00
// - offset signed integer, magnitude up to 10000
// - margins 0..20000 above and below reference
// - output high when enabled and outside window
// - output low inside window or enable low
// - retentivity option keeps state over restart
// - margins may come from another block
// - watchdog decimals only for display
// - input channel represented as 0..1000
// - input selectable among channels, flags, blocks, terminals
// - amplifier outputs the scaled input
// - amplifier result within plus/minus 32767
// - amplifier decimals only for display
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/100ps
`include "asw_cfg.svh"

module asw_top
    import asw_pkg::*;
#(
    parameter int NBLK = 16  // number of block outputs
)(
    input  wire logic                      sys_clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      en_i,
    input  wire logic [7:0][15:0]          analog_input_channel_i,
    input  wire logic [5:0][15:0]          analog_flag_i,
    input  wire logic [NBLK-1:0][15:0]     block_value_i,
    input  wire logic [1:0][15:0]          analog_output_terminal_i,
    input  wire logic [5:0]                addr_i,
    input  wire logic [31:0]               wdata_i,
    input  wire logic                      wr_i,
    input  wire logic                      rd_i,
    output logic [31:0]                    rdata_o,
    output logic                           q_o,
    output logic signed [15:0]             analog_result_o,
    output logic                           irq_o
);

    // ==========================================================
    // helper functions

    // clamp a value into [lo, hi]
    function automatic logic signed [31:0] clampw(
        input logic signed [31:0] x,
        input logic signed [31:0] lo,
        input logic signed [31:0] hi
    );
        logic signed [31:0] r;
        r = x;
        if (x > hi)
        begin
            r = hi;
        end
        else if (x < lo)
        begin
            r = lo;
        end
        return r;
    endfunction : clampw

    // gain in hundredths, then offset, saturated
    function automatic logic signed [15:0] scale(
        input logic signed [15:0] v,
        input logic signed [10:0] g,
        input logic signed [14:0] o
    );
        logic signed [31:0] p;
        p = (32'(v) * 32'(g)) / `ASW_GAIN_DIV + 32'(o);
        p = clampw(p, -`ASW_RES_MAX, `ASW_RES_MAX);
        return p[15:0];
    endfunction : scale

    // output of another block by number, zero if absent
    function automatic logic signed [15:0] pick_blk(
        input logic [7:0] n
    );
        logic signed [15:0] v;
        v = 16'sh0000;
        if (32'(n) < NBLK)
        begin
            v = $signed(block_value_i[n]);
        end
        return v;
    endfunction : pick_blk

    // analog source selection for either path
    function automatic logic signed [15:0] pick_src(
        input asw_src_t s
    );
        logic signed [15:0] v;
        logic signed [31:0] c;
        v = 16'sh0000;
        c = 32'sh0;
        case (s.kind)
            ASW_K_CHAN:
            begin
                if (s.idx < 6'h08)
                begin
                    c = 32'($signed(analog_input_channel_i[s.idx[2:0]]));
                    c = clampw(c, 32'sh0, `ASW_AIN_MAX);
                    v = c[15:0];
                end
            end
            ASW_K_FLAG:
            begin
                if (s.idx < 6'h06)
                begin
                    v = $signed(analog_flag_i[s.idx[2:0]]);
                end
            end
            ASW_K_BLK:
            begin
                v = pick_blk({2'h0, s.idx});
            end
            ASW_K_TERM:
            begin
                v = $signed(analog_output_terminal_i[s.idx[0]]);
            end
            default:
            begin
                v = 16'sh0000;
            end
        endcase
        return v;
    endfunction : pick_src

    // ==========================================================
    // state and combinational terms

    asw_state_t         st;          // registered state
    asw_state_t         nx;          // next state
    asw_bus_t           bus;         // bundled bus request
    logic signed [15:0] wd_scaled_w;  // scaled watchdog input
    logic signed [15:0] amp_scaled_w; // scaled amplifier input
    logic signed [15:0] mhi_w;        // effective upper margin
    logic signed [15:0] mlo_w;        // effective lower margin
    logic               outside_w;    // input outside the window
    logic               rise_w;       // enable low to high
    logic               restart_w;    // restart request
    logic [2:0]         ev_w;         // interrupt events
    logic signed [31:0] up_w;         // window top
    logic signed [31:0] dn_w;         // window bottom
    logic signed [31:0] tmp_w;        // clamp scratch

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    // ==========================================================
    // next state
    always_comb
    begin
        nx    = st;
        tmp_w = 32'sh0;
        // shared scaling stage for both paths
        wd_scaled_w  = scale(pick_src(st.wd_src_r), st.gain_r, st.offs_r);
        amp_scaled_w = scale(pick_src(st.amp_src_r), st.gain_r, st.offs_r);
        // margins: constant or live block output
        mhi_w = st.mhi_r;
        mlo_w = st.mlo_r;
        if (st.msrc_hi_r)
        begin
            tmp_w = clampw(32'(pick_blk(st.mhi_blk_r)), 32'sh0, `ASW_MARG_MAX);
            mhi_w = tmp_w[15:0];
        end
        if (st.msrc_lo_r)
        begin
            tmp_w = clampw(32'(pick_blk(st.mlo_blk_r)), 32'sh0, `ASW_MARG_MAX);
            mlo_w = tmp_w[15:0];
        end
        // enable pin: three flops, change counts when last two agree
        nx.sync = {st.sync[1:0], en_i};
        if (st.sync[1] == st.sync[2])
        begin
            nx.en_lvl = st.sync[2];
        end
        rise_w    = nx.en_lvl & ~st.en_lvl;
        restart_w = bus.wr && (bus.addr == `ASW_A_CTRL)
                    && bus.wdata[`ASW_CTRL_RESTART];
        // capture on enable rise, hold otherwise
        if (rise_w)
        begin
            nx.ref_r = wd_scaled_w;
        end
        // window check against the reference in use next
        up_w      = 32'(nx.ref_r) + 32'(mhi_w);
        dn_w      = 32'(nx.ref_r) - 32'(mlo_w);
        outside_w = (32'(wd_scaled_w) > up_w) || (32'(wd_scaled_w) < dn_w);
        nx.q_r    = nx.en_lvl & outside_w;
        // restart without retention forgets state
        if (restart_w && !st.retain_r)
        begin
            nx.ref_r = 16'sh0000;
            nx.q_r   = 1'b0;
        end
        // amplifier result
        nx.amp_r = amp_scaled_w;
        // register writes
        if (bus.wr)
        begin
            case (bus.addr)
                `ASW_A_CTRL:
                begin
                    nx.retain_r = bus.wdata[`ASW_CTRL_RETAIN];
                end
                `ASW_A_WDSRC:
                begin
                    nx.wd_src_r = asw_src_t'(bus.wdata[7:0]);
                end
                `ASW_A_AMPSRC:
                begin
                    nx.amp_src_r = asw_src_t'(bus.wdata[7:0]);
                end
                `ASW_A_GAIN:
                begin
                    tmp_w = clampw($signed(bus.wdata), -`ASW_GAIN_MAX, `ASW_GAIN_MAX);
                    nx.gain_r = tmp_w[10:0];
                end
                `ASW_A_OFFS:
                begin
                    tmp_w = clampw($signed(bus.wdata), -`ASW_OFFS_MAX, `ASW_OFFS_MAX);
                    nx.offs_r = tmp_w[14:0];
                end
                `ASW_A_MHI:
                begin
                    tmp_w = clampw($signed(bus.wdata), 32'sh0, `ASW_MARG_MAX);
                    nx.mhi_r = tmp_w[15:0];
                end
                `ASW_A_MLO:
                begin
                    tmp_w = clampw($signed(bus.wdata), 32'sh0, `ASW_MARG_MAX);
                    nx.mlo_r = tmp_w[15:0];
                end
                `ASW_A_MSRC:
                begin
                    nx.msrc_hi_r = bus.wdata[`ASW_MSRC_HI];
                    nx.msrc_lo_r = bus.wdata[`ASW_MSRC_LO];
                    nx.mhi_blk_r = bus.wdata[15:8];
                    nx.mlo_blk_r = bus.wdata[23:16];
                end
                `ASW_A_DEC:
                begin
                    nx.wd_dec_r  = bus.wdata[1:0];
                    nx.amp_dec_r = bus.wdata[5:4];
                end
                `ASW_A_IMASK:
                begin
                    nx.imask_r = bus.wdata[2:0];
                end
                default:
                begin
                    nx.imask_r = nx.imask_r;
                end
            endcase
        end
        // sticky events; a set in the clearing cycle wins
        ev_w = 3'h0;
        ev_w[`ASW_IRQ_QSET] = nx.q_r & ~st.q_r;
        ev_w[`ASW_IRQ_QCLR] = ~nx.q_r & st.q_r;
        ev_w[`ASW_IRQ_CAP]  = rise_w;
        if (bus.wr && (bus.addr == `ASW_A_ISTAT))
        begin
            nx.istat_r = st.istat_r & ~bus.wdata[2:0];
        end
        nx.istat_r = nx.istat_r | ev_w;
        nx.irq_r   = |(nx.istat_r & nx.imask_r);
        // read data stand for one cycle only
        nx.rdata_r = 32'h0000_0000;
        if (bus.rd)
        begin
            case (bus.addr)
                `ASW_A_CTRL:   nx.rdata_r = {31'h0, st.retain_r};
                `ASW_A_WDSRC:  nx.rdata_r = {24'h0, st.wd_src_r};
                `ASW_A_AMPSRC: nx.rdata_r = {24'h0, st.amp_src_r};
                `ASW_A_GAIN:   nx.rdata_r = 32'(st.gain_r);
                `ASW_A_OFFS:   nx.rdata_r = 32'(st.offs_r);
                `ASW_A_MHI:    nx.rdata_r = 32'(st.mhi_r);
                `ASW_A_MLO:    nx.rdata_r = 32'(st.mlo_r);
                `ASW_A_MSRC:
                begin
                    nx.rdata_r = {8'h00, st.mlo_blk_r, st.mhi_blk_r,
                                  6'h00, st.msrc_lo_r, st.msrc_hi_r};
                end
                `ASW_A_DEC:
                begin
                    nx.rdata_r = {26'h0, st.amp_dec_r, 2'h0, st.wd_dec_r};
                end
                `ASW_A_STAT:
                begin
                    nx.rdata_r = {29'h0, st.retain_r, st.en_lvl, st.q_r};
                end
                `ASW_A_REF:    nx.rdata_r = 32'(st.ref_r);
                `ASW_A_WDVAL:  nx.rdata_r = 32'(wd_scaled_w);
                `ASW_A_AMPVAL: nx.rdata_r = 32'(st.amp_r);
                `ASW_A_ISTAT:  nx.rdata_r = {29'h0, st.istat_r};
                `ASW_A_IMASK:  nx.rdata_r = {29'h0, st.imask_r};
                default:       nx.rdata_r = 32'h0000_0000;
            endcase
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge sys_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            st        <= '0;
            st.gain_r <= `ASW_RST_GAIN;
        end
        else
        begin
            st <= nx;
        end
    end

    // outputs straight from flops
    assign rdata_o         = st.rdata_r;
    assign q_o             = st.q_r;
    assign analog_result_o = st.amp_r;
    assign irq_o           = st.irq_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    // reference equals scaled input seen at the rise
    cap_ref_a: assert property (
        $rose(st.en_lvl) && !$past(restart_w)
        |-> st.ref_r == $past(wd_scaled_w))
        else $error("reference not captured on enable rise");

    // reference holds while enable stays high
    ref_hold_a: assert property (
        st.en_lvl && $past(st.en_lvl) && !$past(restart_w)
        |-> $stable(st.ref_r))
        else $error("reference changed while enable high");

    // output set when enabled and outside
    q_set_a: assert property (
        nx.en_lvl && outside_w && !restart_w |=> q_o)
        else $error("output not set outside window");

    // output clear inside window
    q_in_a: assert property (
        !outside_w |=> !q_o)
        else $error("output set inside window");

    // output clear while enable low
    q_en_a: assert property (
        !st.en_lvl |-> !q_o)
        else $error("output set with enable low");

    // gain stays within range
    gain_rng_a: assert property (
        32'(st.gain_r) <= `ASW_GAIN_MAX && 32'(st.gain_r) >= -`ASW_GAIN_MAX)
        else $error("gain out of range");

    // offset stays within range
    offs_rng_a: assert property (
        32'(st.offs_r) <= `ASW_OFFS_MAX && 32'(st.offs_r) >= -`ASW_OFFS_MAX)
        else $error("offset out of range");

    // margins stay within range
    marg_rng_a: assert property (
        st.mhi_r >= 0 && 32'(st.mhi_r) <= `ASW_MARG_MAX
        && st.mlo_r >= 0 && 32'(st.mlo_r) <= `ASW_MARG_MAX)
        else $error("margin out of range");

    // amplifier result follows scaled input
    amp_val_a: assert property (
        ##1 analog_result_o == $past(amp_scaled_w))
        else $error("amplifier result mismatch");

    // amplifier result saturated
    amp_rng_a: assert property (
        32'(analog_result_o) <= `ASW_RES_MAX
        && 32'(analog_result_o) >= -`ASW_RES_MAX)
        else $error("amplifier result out of range");

    // non-retentive restart clears reference
    rst_clr_a: assert property (
        restart_w && !st.retain_r |=> st.ref_r == 16'sh0000 && !q_o)
        else $error("restart did not clear state");

endmodule : asw_top

// *** verilog/asw_cfg.svh ***
`ifndef ASW_CFG_SVH
`define ASW_CFG_SVH
// ==========================================================
// register byte offsets
`define ASW_A_CTRL   6'h00
`define ASW_A_WDSRC  6'h04
`define ASW_A_AMPSRC 6'h08
`define ASW_A_GAIN   6'h0C
`define ASW_A_OFFS   6'h10
`define ASW_A_MHI    6'h14
`define ASW_A_MLO    6'h18
`define ASW_A_MSRC   6'h1C
`define ASW_A_DEC    6'h20
`define ASW_A_STAT   6'h24
`define ASW_A_REF    6'h28
`define ASW_A_WDVAL  6'h2C
`define ASW_A_AMPVAL 6'h30
`define ASW_A_ISTAT  6'h34
`define ASW_A_IMASK  6'h38
// ==========================================================
// field positions
`define ASW_CTRL_RETAIN  0
`define ASW_CTRL_RESTART 1
`define ASW_MSRC_HI      0
`define ASW_MSRC_LO      1
`define ASW_IRQ_QSET     0
`define ASW_IRQ_QCLR     1
`define ASW_IRQ_CAP      2
// ==========================================================
// value limits
`define ASW_GAIN_MAX 32'sh3E8
`define ASW_OFFS_MAX 32'sh2710
`define ASW_MARG_MAX 32'sh4E20
`define ASW_RES_MAX  32'sh7FFF
`define ASW_AIN_MAX  32'sh3E8
`define ASW_GAIN_DIV 32'sh64
// ==========================================================
// reset values
`define ASW_RST_GAIN 11'sh064
`endif

// *** verilog/asw_pkg.sv ***
// ==========================================================
// types of the analog scale watchdog
package asw_pkg;
    // kind of analog source
    typedef enum logic [1:0] {
        ASW_K_CHAN = 2'b00,
        ASW_K_FLAG = 2'b01,
        ASW_K_BLK  = 2'b10,
        ASW_K_TERM = 2'b11
    } asw_kind_t;
    // source selector: kind plus index
    typedef struct packed {
        asw_kind_t  kind;
        logic [5:0] idx;
    } asw_src_t;
    // register bus request
    typedef struct packed {
        logic [5:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } asw_bus_t;
    // complete state of the block
    typedef struct packed {
        logic [2:0]         sync;
        logic               en_lvl;
        logic               q_r;
        logic signed [15:0] ref_r;
        logic signed [15:0] amp_r;
        logic               retain_r;
        asw_src_t           wd_src_r;
        asw_src_t           amp_src_r;
        logic signed [10:0] gain_r;
        logic signed [14:0] offs_r;
        logic signed [15:0] mhi_r;
        logic signed [15:0] mlo_r;
        logic               msrc_hi_r;
        logic               msrc_lo_r;
        logic [7:0]         mhi_blk_r;
        logic [7:0]         mlo_blk_r;
        logic [1:0]         wd_dec_r;
        logic [1:0]         amp_dec_r;
        logic [2:0]         istat_r;
        logic [2:0]         imask_r;
        logic               irq_r;
        logic [31:0]        rdata_r;
    } asw_state_t;
endpackage : asw_pkg

// *** sim/asw_src_model.sv ***
`timescale 1ns/100ps
// ==========================================================
// analog sources on the far side of the block
module asw_src_model
    import asw_pkg::*;
#(
    parameter int NBLK = 16  // number of block outputs
)(
    input  wire logic signed [15:0] level_i,  // commanded process level
    input  wire logic signed [15:0] amp_i,    // amplifier result fed back
    output logic [7:0][15:0]        chan_o,   // input channels
    output logic [5:0][15:0]        flag_o,   // analog flags
    output logic [NBLK-1:0][15:0]   blk_o,    // other block outputs
    output logic [1:0][15:0]        term_o    // output terminals
);
    // ==========================================================
    // channels, flags and terminal 0 are offset copies of the level; blocks hold fixed steps
    always_comb
    begin
        for (int k = 0; k < 8; k++)
            chan_o[k] = level_i + 16'(k);
        for (int k = 0; k < 6; k++)
            flag_o[k] = level_i - 16'(k);
        for (int k = 0; k < NBLK; k++)
            blk_o[k] = 16'(k * 100);
        term_o[0] = level_i + 16'h0002;
        // result reaches terminal 1 only after clamping to 0..1000
        if (amp_i < 0)
            term_o[1] = 16'h0000;
        else if (amp_i > 16'sh03E8)
            term_o[1] = 16'h03E8;
        else
            term_o[1] = amp_i;
    end
endmodule : asw_src_model

// *** sim/asw_top_test.sv ***
`timescale 1ns/100ps
`include "asw_cfg.svh"
// ==========================================================
// self-checking bench of the analog scale watchdog
module asw_top_test
    import asw_pkg::*;
;
    logic                  sys_clk_i = 1'b0;     // system clock
    logic                  reset_n_i = 1'b0;     // reset, active low
    logic                  en_i      = 1'b0;     // watchdog enable
    logic signed [15:0]    level_r   = 16'h0000; // commanded source level
    logic [5:0]            addr_i    = 6'h00;    // bus address
    logic [31:0]           wdata_i   = 32'h0;    // bus write data
    logic                  wr_i      = 1'b0;     // write strobe
    logic                  rd_i      = 1'b0;     // read strobe
    logic [31:0]           rdata_o;              // read data
    logic                  q_o;                  // watchdog output
    logic signed [15:0]    analog_result_o;      // amplifier result
    logic                  irq_o;                // interrupt
    logic [7:0][15:0]      chan;                 // channel values
    logic [5:0][15:0]      flag;                 // flag values
    logic [15:0][15:0]     blk;                  // block values
    logic [1:0][15:0]      term;                 // terminal values
    int                    mismatches = 0;       // failed compares
    int                    checks     = 0;       // compares made
    int                    cycles     = 0;       // timeout counter

    always #10 sys_clk_i = ~sys_clk_i;

    asw_top u_asw_top (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .en_i(en_i),
        .analog_input_channel_i(chan), .analog_flag_i(flag), .block_value_i(blk),
        .analog_output_terminal_i(term), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .q_o(q_o), .analog_result_o(analog_result_o),
        .irq_o(irq_o));
    asw_src_model u_asw_src_model (.level_i(level_r), .amp_i(analog_result_o),
        .chan_o(chan), .flag_o(flag), .blk_o(blk), .term_o(term));

    // ==========================================================
    // helpers
    task automatic tally_and_finish;
        if (mismatches == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : tally_and_finish

    // hang guard, far above the expected run length
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : wait_clk

    task automatic bus_wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask : bus_wr

    // data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(rdata_o, exp);
    endtask : rd_chk

    task automatic set_lvl(input int v);
        @(posedge sys_clk_i);
        level_r <= 16'(v);
        wait_clk(3);
    endtask : set_lvl

    task automatic set_en(input logic v);
        @(posedge sys_clk_i);
        en_i <= v;
        wait_clk(6);
    endtask : set_en

    // expected scaling: truncating divide by 100, then saturation
    function automatic int scale(input int v, input int g, input int o);
        int s;
        s = (v * g) / 100 + o;
        return (s > 32767) ? 32767 : ((s < -32767) ? -32767 : s);
    endfunction : scale

    // ==========================================================
    // scenarios
    task automatic t_regs;
        rd_chk(`ASW_A_GAIN, 32'h0000_0064);
        bus_wr(`ASW_A_GAIN, 32'h0000_07D0);
        rd_chk(`ASW_A_GAIN, 32'h0000_03E8);
        bus_wr(`ASW_A_GAIN, 32'hFFFF_F830);
        rd_chk(`ASW_A_GAIN, 32'hFFFF_FC18);
        bus_wr(`ASW_A_OFFS, 32'hFFFF_B1E0);
        rd_chk(`ASW_A_OFFS, 32'hFFFF_D8F0);
        bus_wr(`ASW_A_MHI, 32'h0000_7530);
        rd_chk(`ASW_A_MHI, 32'h0000_4E20);
        bus_wr(`ASW_A_MLO, 32'hFFFF_FFF6);
        rd_chk(`ASW_A_MLO, 32'h0000_0000);
        rd_chk(6'h3C, 32'h0000_0000);
    endtask : t_regs

    task automatic t_amp;
        logic [7:0] sel [4] = '{8'h03, 8'h42, 8'h85, 8'hC0};
        int         vin [4] = '{403, 398, 500, 402};
        bus_wr(`ASW_A_GAIN, 32'h0000_00FA);
        bus_wr(`ASW_A_OFFS, 32'hFFFF_FFD8);
        set_lvl(400);
        for (int i = 0; i < 4; i++)
        begin
            bus_wr(`ASW_A_AMPSRC, {24'h0, sel[i]});
            wait_clk(3);
            chk(32'(analog_result_o), 32'(scale(vin[i], 250, -40)));
        end
        rd_chk(`ASW_A_AMPVAL, 32'(scale(402, 250, -40)));
        bus_wr(`ASW_A_DEC, 32'h0000_0033);
        wait_clk(2);
        chk(32'(analog_result_o), 32'(scale(402, 250, -40)));
        // channel index past the last channel reads as zero
        bus_wr(`ASW_A_AMPSRC, 32'h0000_0009);
        wait_clk(3);
        chk(32'(analog_result_o), 32'(scale(0, 250, -40)));
        bus_wr(`ASW_A_AMPSRC, 32'h0000_0000);
        set_lvl(1500);
        chk(32'(analog_result_o), 32'(scale(1000, 250, -40)));
        bus_wr(`ASW_A_GAIN, 32'h0000_03E8);
        bus_wr(`ASW_A_OFFS, 32'h0000_2710);
        bus_wr(`ASW_A_AMPSRC, 32'h0000_0040);
        set_lvl(5000);
        chk(32'(analog_result_o), 32'h0000_7FFF);
        set_lvl(-5000);
        chk(32'(analog_result_o), 32'hFFFF_8001);
    endtask : t_amp

    task automatic t_wd;
        int   lv [5] = '{125, 126, 90, 84, 100};
        logic qx [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
        bus_wr(`ASW_A_GAIN, 32'h0000_00C8);
        bus_wr(`ASW_A_OFFS, 32'h0000_000A);
        bus_wr(`ASW_A_MHI, 32'h0000_0032);
        bus_wr(`ASW_A_MLO, 32'h0000_001E);
        bus_wr(`ASW_A_WDSRC, 32'h0000_0000);
        set_lvl(100);
        set_en(1'b1);
        rd_chk(`ASW_A_REF, 32'h0000_00D2);
        chk(32'(q_o), 32'h0);
        for (int i = 0; i < 5; i++)
        begin
            set_lvl(lv[i]);
            chk(32'(q_o), 32'(qx[i]));
        end
        set_lvl(126);
        bus_wr(`ASW_A_DEC, 32'h0000_0003);
        wait_clk(2);
        chk(32'(q_o), 32'h1);
        rd_chk(`ASW_A_STAT, 32'h0000_0003);
        rd_chk(`ASW_A_WDVAL, 32'h0000_0106);
        rd_chk(`ASW_A_REF, 32'h0000_00D2);
        set_en(1'b0);
        chk(32'(q_o), 32'h0);
        set_lvl(50);
        set_en(1'b1);
        rd_chk(`ASW_A_REF, 32'h0000_006E);
        bus_wr(`ASW_A_MSRC, 32'h0000_0101);
        set_lvl(100);
        chk(32'(q_o), 32'h0);
        set_lvl(101);
        chk(32'(q_o), 32'h1);
        // lower margin from block 2 widens the window below the reference
        bus_wr(`ASW_A_MSRC, 32'h0002_0103);
        set_lvl(10);
        chk(32'(q_o), 32'h0);
        // restart obeys the retention held before the write, so set it first
        bus_wr(`ASW_A_CTRL, 32'h0000_0001);
        bus_wr(`ASW_A_CTRL, 32'h0000_0003);
        rd_chk(`ASW_A_REF, 32'h0000_006E);
        rd_chk(`ASW_A_CTRL, 32'h0000_0001);
        bus_wr(`ASW_A_CTRL, 32'h0000_0000);
        bus_wr(`ASW_A_CTRL, 32'h0000_0002);
        rd_chk(`ASW_A_REF, 32'h0000_0000);
        set_en(1'b0);
        chk(32'(q_o), 32'h0);
    endtask : t_wd

    task automatic t_irq;
        rd_chk(`ASW_A_ISTAT, 32'h0000_0007);
        chk(32'(irq_o), 32'h0);
        bus_wr(`ASW_A_IMASK, 32'h0000_0004);
        wait_clk(2);
        chk(32'(irq_o), 32'h1);
        bus_wr(`ASW_A_ISTAT, 32'h0000_0004);
        wait_clk(2);
        chk(32'(irq_o), 32'h0);
        rd_chk(`ASW_A_ISTAT, 32'h0000_0003);
    endtask : t_irq

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (12) @(posedge sys_clk_i);
        reset_n_i <= 1'b1;
        t_regs();
        t_amp();
        t_wd();
        t_irq();
        tally_and_finish();
    end
endmodule : asw_top_test
